// ==== rtl/rsm_pkg.sv ====
// constants, types and state layout for the reference select and mode controller
package rsm_pkg;
  typedef enum logic [2:0] {
    state_free = 3'h0,
    state_tracking = 3'h1,
    state_auto_hold = 3'h2,
    state_manual_hold = 3'h3,
    state_short_hold = 3'h4
  } rsm_state_e;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] RATE_19M44 = 2'h0;
  localparam logic [1:0] RATE_8K = 2'h1;
  localparam logic [1:0] RATE_1M544 = 2'h2;
  localparam logic [1:0] RATE_2M048 = 2'h3;
  localparam longint HZ_19M44 = 64'd19440000;
  localparam longint HZ_8K = 64'd8000;
  localparam longint HZ_1M544 = 64'd1544000;
  localparam longint HZ_2M048 = 64'd2048000;
  localparam longint CLK_HZ = 64'd250000000;
  localparam longint PPM_TOL = 64'd12;
  localparam int CLK_NS = 4;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
  localparam int ACQ_MS = 30000;
  localparam int FAST_ACQ_MS = 500;
  localparam int STORE_MS = 30;
  localparam int MON_MS = 2000;
  // grouped so that the product stays inside 32 bits
  localparam int ACQ_FRAMES = ACQ_MS * (1000000 / FRAME_NS);
  localparam int FAST_ACQ_FRAMES = FAST_ACQ_MS * 1000000 / FRAME_NS;
  localparam int STORE_FRAMES = STORE_MS * 1000000 / FRAME_NS;
  localparam int MON_FRAMES = MON_MS * 1000000 / FRAME_NS;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_HOLD = 8'h08;
  localparam int CTRL_OPSEL = 0;
  localparam int CTRL_REFSEL = 2;
  localparam int CTRL_PCE = 3;
  localparam int CTRL_QACQ = 4;
  localparam int CTRL_RATE_A = 5;
  localparam int CTRL_RATE_B = 7;
  localparam int CTRL_RESTART = 9;
  localparam logic [8:0] CTRL_RST = 9'h002;
  localparam int STAT_CORR = 3;
  localparam int STAT_ACTREF = 4;
  localparam int STAT_ACQTO = 5;
  localparam int STAT_FLAG_A = 6;
  localparam int STAT_FLAG_B = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rsm_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsm_axi_rsp_s;
  typedef struct packed {
    rsm_state_e st;
    logic corr;
    logic act_ref;
    logic sel_q;
    logic sel_seen;
    logic init;
    logic frame;
    logic ref_edge;
    logic [14:0] fcnt;
    logic [7:0] scnt;
    logic [1:0][31:0] slot;
    logic wr;
    logic [31:0] hold_word;
    logic [17:0] lcnt;
    logic acq_to;
    logic [13:0] mcnt;
    logic [1:0] rate_a;
    logic [1:0] rate_b;
    logic ra_q;
    logic rb_q;
    logic [25:0] cnt_a;
    logic [25:0] cnt_b;
    logic flag_a;
    logic flag_b;
    logic [8:0] ctrl;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsm_regs_s;
endpackage

// ==== rtl/rsm_ref_select_ctrl.sv ====
// operating mode state machine, reference selection and monitoring with AXI4-Lite registers
`timescale 1ns/1ps
module rsm_ref_select_ctrl #(
  parameter int FRAME_CYCLES = rsm_pkg::FRAME_CYCLES,
  parameter int ACQ_FRAMES = rsm_pkg::ACQ_FRAMES,
  parameter int FAST_ACQ_FRAMES = rsm_pkg::FAST_ACQ_FRAMES,
  parameter int STORE_FRAMES = rsm_pkg::STORE_FRAMES,
  parameter int MON_FRAMES = rsm_pkg::MON_FRAMES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire rsm_pkg::rsm_axi_req_s AXI_REQ,
  output rsm_pkg::rsm_axi_rsp_s AXI_RSP,
  input wire logic REF_A_INPUT,
  input wire logic REF_B_INPUT,
  input wire logic REF_INVALID,
  input wire logic LOCKED,
  input wire logic [31:0] FREQ_WORD,
  output logic FRAME_PULSE_8K,
  output logic REF_EDGE,
  output logic PHASE_STEP_CORRECTION,
  output logic QUICK_ACQUIRE_EN,
  output logic HOLD_ACTIVE,
  output logic [31:0] HOLD_WORD,
  output logic OSC_ONLY,
  output logic STATE_NORMAL,
  output logic STATE_HOLDOVER,
  output logic STATE_FREERUN,
  output logic REF_A_OFFSET_FLAG,
  output logic REF_B_OFFSET_FLAG
);
  localparam longint WIN_CYCLES = longint'(FRAME_CYCLES) * longint'(MON_FRAMES);

  if (FRAME_CYCLES < 2 || FRAME_CYCLES > 32767 || ACQ_FRAMES < 1 || ACQ_FRAMES > 262143 ||
      FAST_ACQ_FRAMES < 1 || FAST_ACQ_FRAMES > 262143 || STORE_FRAMES < 1 ||
      STORE_FRAMES > 255 || MON_FRAMES < 1 || MON_FRAMES > 16383 ||
      WIN_CYCLES > 64'd500000000) begin : g_bad_params
    $error("rsm_ref_select_ctrl: parameter out of range");
  end

  rsm_pkg::rsm_regs_s s;
  rsm_pkg::rsm_regs_s n;
  rsm_pkg::rsm_state_e nst;
  logic [1:0] mode;
  logic a_edge;
  logic b_edge;
  logic sel_chg;
  logic do_wr;
  logic [31:0] older;

  // edge of a reference by its rate: rising only for the fastest rate
  function automatic logic ref_edge_of(input logic [1:0] rate, input logic cur,
                                       input logic prev);
    if (rate == rsm_pkg::RATE_19M44) begin
      return cur & ~prev;
    end
    return ~cur & prev;
  endfunction

  function automatic longint rate_hz(input logic [1:0] rate);
    unique case (rate)
      rsm_pkg::RATE_19M44: return rsm_pkg::HZ_19M44;
      rsm_pkg::RATE_8K: return rsm_pkg::HZ_8K;
      rsm_pkg::RATE_1M544: return rsm_pkg::HZ_1M544;
      rsm_pkg::RATE_2M048: return rsm_pkg::HZ_2M048;
    endcase
  endfunction

  // true when the edge count of a window is off nominal by more than the tolerance
  function automatic logic off_nominal(input logic [1:0] rate, input logic [25:0] cnt);
    longint expct;
    longint tol;
    longint c;
    expct = rate_hz(rate) * WIN_CYCLES / rsm_pkg::CLK_HZ;
    tol = expct * rsm_pkg::PPM_TOL / 64'd1000000;
    c = longint'(cnt);
    return (c > expct + tol) || (c + tol < expct);
  endfunction

  function automatic logic is_hold(input rsm_pkg::rsm_state_e st);
    return st inside {rsm_pkg::state_auto_hold, rsm_pkg::state_manual_hold,
                      rsm_pkg::state_short_hold};
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return addr[7:2] inside {rsm_pkg::ADDR_CTRL[7:2], rsm_pkg::ADDR_STATUS[7:2],
                             rsm_pkg::ADDR_HOLD[7:2]};
  endfunction

  always_comb begin
    n = s;
    nst = s.st;
    mode = s.ctrl[rsm_pkg::CTRL_OPSEL +: 2];
    older = s.slot[~s.wr];
    n.frame = 1'b0;
    if (s.fcnt == 15'(FRAME_CYCLES - 1)) begin
      n.fcnt = '0;
      n.frame = 1'b1;
    end else begin
      n.fcnt = s.fcnt + 15'h0001;
    end
    n.ra_q = REF_A_INPUT;
    n.rb_q = REF_B_INPUT;
    a_edge = ref_edge_of(s.rate_a, REF_A_INPUT, s.ra_q);
    b_edge = ref_edge_of(s.rate_b, REF_B_INPUT, s.rb_q);
    // freerun runs from the local oscillator only
    n.ref_edge = (s.st != rsm_pkg::state_free) && (s.act_ref ? b_edge : a_edge);
    n.sel_q = s.ctrl[rsm_pkg::CTRL_REFSEL];
    sel_chg = s.ctrl[rsm_pkg::CTRL_REFSEL] != s.sel_q;
    // a select change in the decision cycle is kept for the next frame
    if (s.frame) begin
      n.sel_seen = sel_chg;
    end else if (sel_chg) begin
      n.sel_seen = 1'b1;
    end
    if (s.frame && mode != rsm_pkg::MODE_RSVD) begin
      unique case (s.st)
        rsm_pkg::state_free: begin
          if (mode == rsm_pkg::MODE_NORMAL) begin
            nst = rsm_pkg::state_tracking;
          end else if (mode == rsm_pkg::MODE_HOLD) begin
            nst = rsm_pkg::state_manual_hold;
          end
        end
        rsm_pkg::state_tracking: begin
          if (mode == rsm_pkg::MODE_FREE) begin
            nst = rsm_pkg::state_free;
          end else if (mode == rsm_pkg::MODE_HOLD) begin
            nst = rsm_pkg::state_manual_hold;
          end else if (s.sel_seen) begin
            nst = rsm_pkg::state_short_hold;
          end else if (REF_INVALID) begin
            nst = rsm_pkg::state_auto_hold;
          end
        end
        rsm_pkg::state_auto_hold: begin
          if (mode == rsm_pkg::MODE_FREE) begin
            nst = rsm_pkg::state_free;
          end else if (mode == rsm_pkg::MODE_HOLD) begin
            nst = rsm_pkg::state_manual_hold;
          end else if (s.sel_seen) begin
            nst = rsm_pkg::state_short_hold;
          end else if (!REF_INVALID) begin
            nst = rsm_pkg::state_tracking;
          end
        end
        rsm_pkg::state_manual_hold: begin
          if (mode == rsm_pkg::MODE_NORMAL) begin
            nst = rsm_pkg::state_tracking;
          end else if (mode == rsm_pkg::MODE_FREE) begin
            nst = rsm_pkg::state_free;
          end
        end
        rsm_pkg::state_short_hold: begin
          if (mode == rsm_pkg::MODE_FREE) begin
            nst = rsm_pkg::state_free;
          end else if (mode == rsm_pkg::MODE_HOLD) begin
            nst = rsm_pkg::state_manual_hold;
          end else if (!s.sel_seen) begin
            nst = rsm_pkg::state_tracking;
          end
        end
        default: nst = rsm_pkg::state_free;
      endcase
    end
    n.st = nst;
    if (nst != s.st) begin
      // only a return to tracking from a hold state lets software decide
      n.corr = (nst == rsm_pkg::state_tracking && is_hold(s.st)) ?
               s.ctrl[rsm_pkg::CTRL_PCE] : 1'b0;
      if (s.st == rsm_pkg::state_tracking && is_hold(nst)) begin
        n.hold_word = older;
      end
    end
    if (nst != rsm_pkg::state_tracking && nst != rsm_pkg::state_auto_hold &&
        !(s.st == rsm_pkg::state_tracking && nst == rsm_pkg::state_short_hold)) begin
      n.act_ref = s.ctrl[rsm_pkg::CTRL_REFSEL];
    end
    if (s.st == rsm_pkg::state_tracking && LOCKED) begin
      if (s.frame) begin
        if (s.scnt >= 8'(STORE_FRAMES - 1)) begin
          n.scnt = '0;
          n.slot[~s.wr] = FREQ_WORD;
          n.wr = ~s.wr;
        end else begin
          n.scnt = s.scnt + 8'h01;
        end
      end
    end else begin
      n.scnt = '0;
    end
    if (s.st != rsm_pkg::state_tracking || LOCKED) begin
      n.lcnt = '0;
      n.acq_to = 1'b0;
    end else if (s.frame && !s.acq_to) begin
      // acquisition watchdog: fast limit under quick acquire
      if (s.lcnt >= (s.ctrl[rsm_pkg::CTRL_QACQ] ? 18'(FAST_ACQ_FRAMES - 1) :
                     18'(ACQ_FRAMES - 1))) begin
        n.acq_to = 1'b1;
      end else begin
        n.lcnt = s.lcnt + 18'h00001;
      end
    end
    n.cnt_a = s.cnt_a + 26'(a_edge);
    n.cnt_b = s.cnt_b + 26'(b_edge);
    if (s.frame) begin
      if (s.mcnt == 14'(MON_FRAMES - 1)) begin
        n.mcnt = '0;
        n.flag_a = off_nominal(s.rate_a, s.cnt_a);
        n.flag_b = off_nominal(s.rate_b, s.cnt_b);
        n.cnt_a = 26'(a_edge);
        n.cnt_b = 26'(b_edge);
      end else begin
        n.mcnt = s.mcnt + 14'h0001;
      end
    end
    // bus write channels, taken in either order
    do_wr = s.aw_ok && s.w_ok;
    if (AXI_REQ.awvalid && !s.aw_ok && !s.bvalid) begin
      n.aw_ok = 1'b1;
      n.aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && !s.w_ok && !s.bvalid) begin
      n.w_ok = 1'b1;
      n.wdata = AXI_REQ.wdata;
      n.wstrb = AXI_REQ.wstrb;
    end
    n.init = 1'b0;
    if (s.init) begin
      n.rate_a = s.ctrl[rsm_pkg::CTRL_RATE_A +: 2];
      n.rate_b = s.ctrl[rsm_pkg::CTRL_RATE_B +: 2];
      n.mcnt = '0;
      n.cnt_a = '0;
      n.cnt_b = '0;
    end
    if (do_wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(s.aw_addr) ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
      if (s.aw_addr[7:2] == rsm_pkg::ADDR_CTRL[7:2]) begin
        if (s.wstrb[0]) begin
          n.ctrl[7:0] = s.wdata[7:0];
        end
        if (s.wstrb[1]) begin
          n.ctrl[8] = s.wdata[8];
          // rates move only through this restart, as after a reset
          n.init = s.wdata[rsm_pkg::CTRL_RESTART];
        end
      end
    end else if (s.bvalid && AXI_REQ.bready) begin
      n.bvalid = 1'b0;
    end
    if (AXI_REQ.arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = mapped(AXI_REQ.araddr) ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
      n.rdata = '0;
      if (AXI_REQ.araddr[7:2] == rsm_pkg::ADDR_CTRL[7:2]) begin
        n.rdata[8:0] = s.ctrl;
      end else if (AXI_REQ.araddr[7:2] == rsm_pkg::ADDR_STATUS[7:2]) begin
        n.rdata[2:0] = s.st;
        n.rdata[rsm_pkg::STAT_CORR] = s.corr;
        n.rdata[rsm_pkg::STAT_ACTREF] = s.act_ref;
        n.rdata[rsm_pkg::STAT_ACQTO] = s.acq_to;
        n.rdata[rsm_pkg::STAT_FLAG_A] = s.flag_a;
        n.rdata[rsm_pkg::STAT_FLAG_B] = s.flag_b;
      end else if (AXI_REQ.araddr[7:2] == rsm_pkg::ADDR_HOLD[7:2]) begin
        n.rdata = s.hold_word;
      end
    end else if (s.rvalid && AXI_REQ.rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.ctrl <= rsm_pkg::CTRL_RST;
      s.rate_a <= rsm_pkg::CTRL_RST[rsm_pkg::CTRL_RATE_A +: 2];
      s.rate_b <= rsm_pkg::CTRL_RST[rsm_pkg::CTRL_RATE_B +: 2];
      s.init <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    AXI_RSP.awready = !s.aw_ok && !s.bvalid;
    AXI_RSP.wready = !s.w_ok && !s.bvalid;
    AXI_RSP.bvalid = s.bvalid;
    AXI_RSP.bresp = s.bresp;
    AXI_RSP.arready = !s.rvalid;
    AXI_RSP.rvalid = s.rvalid;
    AXI_RSP.rdata = s.rdata;
    AXI_RSP.rresp = s.rresp;
  end

  assign FRAME_PULSE_8K = s.frame;
  assign REF_EDGE = s.ref_edge;
  assign PHASE_STEP_CORRECTION = s.corr;
  assign QUICK_ACQUIRE_EN = s.ctrl[rsm_pkg::CTRL_QACQ] && s.st == rsm_pkg::state_tracking;
  assign HOLD_ACTIVE = is_hold(s.st);
  assign HOLD_WORD = s.hold_word;
  assign OSC_ONLY = s.st == rsm_pkg::state_free;
  assign STATE_NORMAL = s.st == rsm_pkg::state_tracking;
  assign STATE_HOLDOVER = is_hold(s.st);
  assign STATE_FREERUN = s.st == rsm_pkg::state_free;
  assign REF_A_OFFSET_FLAG = s.flag_a;
  assign REF_B_OFFSET_FLAG = s.flag_b;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_state_on_frame: assert property (s.st != $past(s.st) |-> $past(s.frame))
    else $error("state changed off the frame pulse");
  a_auto_hold_entry: assert property (s.frame && s.st == rsm_pkg::state_tracking &&
      mode == rsm_pkg::MODE_NORMAL && !s.sel_seen && REF_INVALID
      |=> s.st == rsm_pkg::state_auto_hold && !PHASE_STEP_CORRECTION)
    else $error("invalid reference did not enter auto hold");
  a_auto_return: assert property (s.frame && s.st == rsm_pkg::state_auto_hold &&
      mode == rsm_pkg::MODE_NORMAL && !s.sel_seen && !REF_INVALID
      |=> STATE_NORMAL && PHASE_STEP_CORRECTION == $past(s.ctrl[rsm_pkg::CTRL_PCE]))
    else $error("auto hold did not return to tracking");
  a_short_entry: assert property (s.frame && s.sel_seen && mode == rsm_pkg::MODE_NORMAL &&
      s.st inside {rsm_pkg::state_tracking, rsm_pkg::state_auto_hold}
      |=> s.st == rsm_pkg::state_short_hold ##0 !PHASE_STEP_CORRECTION[*2])
    else $error("select change did not enter short hold");
  a_short_settle: assert property (s.frame && s.st == rsm_pkg::state_short_hold &&
      mode == rsm_pkg::MODE_NORMAL && !s.sel_seen
      |=> STATE_NORMAL && s.act_ref == $past(s.ctrl[rsm_pkg::CTRL_REFSEL]))
    else $error("short hold did not settle on the new reference");
  a_corr_off_change: assert property (s.st != $past(s.st) &&
      !(s.st == rsm_pkg::state_tracking && $past(HOLD_ACTIVE)) |-> !PHASE_STEP_CORRECTION)
    else $error("correction left on across a state change");
  a_reserved_keep: assert property (s.frame && mode == rsm_pkg::MODE_RSVD |=> $stable(s.st))
    else $error("reserved mode code moved the state");
  a_free_no_ref: assert property (OSC_ONLY ##1 OSC_ONLY |-> !REF_EDGE)
    else $error("reference edge passed in freerun");
  a_flags_steady: assert property (!$past(s.frame) || $past(s.mcnt) != 14'(MON_FRAMES - 1)
      |-> $stable(REF_A_OFFSET_FLAG) && $stable(REF_B_OFFSET_FLAG))
    else $error("offset flag moved outside its update");
  a_hold_capture: assert property (s.st == rsm_pkg::state_tracking && n.st != s.st &&
      is_hold(n.st) |=> HOLD_WORD == $past(older) && HOLD_ACTIVE)
    else $error("hold word not taken from the older slot");
endmodule // rsm_ref_select_ctrl

// ==== sim/rsm_ref_partner.sv ====
// reference clock pair driven towards the mode controller
`timescale 1ns/1ps
module rsm_ref_partner (
  input wire logic CLK,
  input wire logic RST,
  input wire logic STOP_B,
  output logic REF_A,
  output logic REF_B
);
  logic [2:0] cnt;
  // a runs at a quarter of CLK, b at an eighth; a stopped b rests low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt <= 3'h0;
      REF_A <= 1'b0;
      REF_B <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      REF_A <= cnt[1];
      REF_B <= cnt[2] & ~STOP_B;
    end
  end
endmodule // rsm_ref_partner

// ==== sim/testbench.sv ====
// self-checking bench for the reference select and mode controller
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  rsm_pkg::rsm_axi_req_s req = '0;
  rsm_pkg::rsm_axi_rsp_s rsp;
  logic ra, rb, fp, edg, corr, qa, hact, oso, sn, sh, sf, fa, fb, x;
  logic stop_b = 1'b0;
  logic inv = 1'b0;
  logic lock = 1'b1;
  logic [31:0] fw = 32'h0000A5A5;
  logic [31:0] rd, hw;
  logic [1:0] rr;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 CLK = ~CLK;
  rsm_ref_partner peer (.CLK(CLK), .RST(RST), .STOP_B(stop_b), .REF_A(ra), .REF_B(rb));
  rsm_ref_select_ctrl #(.FRAME_CYCLES(50), .ACQ_FRAMES(20), .FAST_ACQ_FRAMES(5),
    .STORE_FRAMES(2), .MON_FRAMES(10)) uut (
    .CLK(CLK), .RST(RST), .AXI_REQ(req), .AXI_RSP(rsp), .REF_A_INPUT(ra),
    .REF_B_INPUT(rb), .REF_INVALID(inv), .LOCKED(lock), .FREQ_WORD(fw),
    .FRAME_PULSE_8K(fp), .REF_EDGE(edg), .PHASE_STEP_CORRECTION(corr),
    .QUICK_ACQUIRE_EN(qa), .HOLD_ACTIVE(hact), .HOLD_WORD(hw), .OSC_ONLY(oso),
    .STATE_NORMAL(sn), .STATE_HOLDOVER(sh), .STATE_FREERUN(sf),
    .REF_A_OFFSET_FLAG(fa), .REF_B_OFFSET_FLAG(fb));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, pa, pw;
    @(posedge CLK);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge CLK);
      ta = pa && rsp.awready;
      tw = pw && rsp.wready;
      tb = rsp.bvalid;
      rr = rsp.bresp;
      @(posedge CLK);
      if (ta) req.awvalid <= 1'b0;
      if (ta) pa = 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tw) pw = 1'b0;
      if (tb) req.bready <= 1'b0;
    end
    @(negedge CLK);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, pa, done;
    @(posedge CLK);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    pa = 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge CLK);
      ta = pa && rsp.arready;
      done = rsp.rvalid;
      rd = rsp.rdata;
      rr = rsp.rresp;
      @(posedge CLK);
      if (ta) req.arvalid <= 1'b0;
      if (ta) pa = 1'b0;
      if (done) req.rready <= 1'b0;
    end
    @(negedge CLK);
  endtask
  // returns one cycle after the frame pulse, when a decision has landed
  task automatic frame;
    @(negedge CLK);
    while (fp !== 1'b1) @(negedge CLK);
    @(negedge CLK);
  endtask
  task automatic st(input logic [2:0] s, input logic c);
    rdr(rsm_pkg::ADDR_STATUS);
    chk({corr, rd[3:0]}, {c, c, s});
    chk({sn, sh, sf, oso, hact}, {s == 3'h1, s > 3'h1, s == 3'h0, s == 3'h0, s > 3'h1});
  endtask
  task automatic edges;
    x = 1'b0;
    repeat (60) begin
      @(negedge CLK);
      x = x | edg;
    end
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rdr(rsm_pkg::ADDR_CTRL);
    chk({rr, rd}, {rsm_pkg::RESP_OKAY, 32'h00000002});
    st(3'h0, 1'b0);
    edges();
    chk(x, 1'b0);
    rdr(8'h0C);
    chk({rr, rd}, {rsm_pkg::RESP_SLVERR, 32'h0});
    wr(rsm_pkg::ADDR_STATUS, 32'hFF);
    chk(rr, rsm_pkg::RESP_OKAY);
    wr(rsm_pkg::ADDR_CTRL, 32'h262);
    rdr(rsm_pkg::ADDR_CTRL);
    chk(rd, 32'h062);
    frame();
    wr(rsm_pkg::ADDR_CTRL, 32'h68);
    st(3'h0, 1'b0);
    frame();
    st(3'h1, 1'b0);
    wr(rsm_pkg::ADDR_CTRL, 32'h78);
    chk(qa, 1'b1);
    wr(rsm_pkg::ADDR_CTRL, 32'h68);
    chk(qa, 1'b0);
    edges();
    chk(x, 1'b1);
    repeat (4) frame();
    // exactly one store of the new word, so the older slot keeps the previous one
    @(posedge CLK) fw <= 32'h00005A5A;
    repeat (2) frame();
    wr(rsm_pkg::ADDR_CTRL, 32'h69);
    frame();
    st(3'h3, 1'b0);
    chk(hw, 32'h0000A5A5);
    rdr(rsm_pkg::ADDR_HOLD);
    chk({rr, rd}, {rsm_pkg::RESP_OKAY, 32'h0000A5A5});
    wr(rsm_pkg::ADDR_CTRL, 32'h6B);
    frame();
    st(3'h3, 1'b0);
    wr(rsm_pkg::ADDR_CTRL, 32'h68);
    frame();
    st(3'h1, 1'b1);
    @(posedge CLK) inv <= 1'b1;
    frame();
    st(3'h2, 1'b0);
    @(posedge CLK) inv <= 1'b0;
    frame();
    st(3'h1, 1'b1);
    wr(rsm_pkg::ADDR_CTRL, 32'h6C);
    frame();
    st(3'h4, 1'b0);
    frame();
    st(3'h1, 1'b1);
    chk(rd[4], 1'b1);
    @(posedge CLK) inv <= 1'b1;
    frame();
    st(3'h2, 1'b0);
    wr(rsm_pkg::ADDR_CTRL, 32'h68);
    @(posedge CLK) inv <= 1'b0;
    frame();
    st(3'h4, 1'b0);
    frame();
    st(3'h1, 1'b1);
    chk(rd[4], 1'b0);
    // acquisition watchdog: quick limit 5 frames, normal limit 20 frames
    wr(rsm_pkg::ADDR_CTRL, 32'h78);
    @(posedge CLK) lock <= 1'b0;
    repeat (4) frame();
    rdr(rsm_pkg::ADDR_STATUS);
    chk(rd[5], 1'b0);
    frame();
    rdr(rsm_pkg::ADDR_STATUS);
    chk(rd[5], 1'b1);
    wr(rsm_pkg::ADDR_CTRL, 32'h68);
    @(posedge CLK) lock <= 1'b1;
    @(posedge CLK) lock <= 1'b0;
    repeat (19) frame();
    rdr(rsm_pkg::ADDR_STATUS);
    chk(rd[5], 1'b0);
    frame();
    rdr(rsm_pkg::ADDR_STATUS);
    chk(rd[5], 1'b1);
    @(posedge CLK) lock <= 1'b1;
    wr(rsm_pkg::ADDR_CTRL, 32'h6A);
    frame();
    st(3'h0, 1'b0);
    edges();
    chk(x, 1'b0);
    @(posedge CLK) stop_b <= 1'b1;
    repeat (25) frame();
    chk(fb, 1'b1);
    chk(fa, 1'b1);
    x = fb;
    repeat (100) @(negedge CLK) x = x & fb;
    chk(x, 1'b1);
    // a new rate without restart must not be applied
    wr(rsm_pkg::ADDR_CTRL, 32'h0EA);
    repeat (12) frame();
    chk(fb, 1'b1);
    // after restart the stopped input matches the 8 kHz nominal of this window
    wr(rsm_pkg::ADDR_CTRL, 32'h2EA);
    repeat (12) frame();
    chk(fb, 1'b0);
    chk(fa, 1'b1);
    tally_and_finish();
  end
endmodule // testbench
